// ===== rtl/spi_nv_memory.sv
`timescale 1ns/1ps
module spi_nv_memory #(
  parameter int WAKE_CYCLES = spi_nv_pkg::REC_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  input  wire logic [1:0] protect_level,
  output logic            so,
  output logic            so_oe
);
  localparam int WW = spi_nv_pkg::WAKE_CNT_W;
  spi_nv_pkg::spi_pins_s sync1_q, sync2_q, prev_q; // Pin synchroniser
  spi_nv_pkg::xfer_e     state_q, state_d;         // Transfer phase
  spi_nv_pkg::pwr_e      pwr_q, pwr_d;             // Power state
  logic [2:0]    bit_cnt_q, bit_cnt_d;   // Bits of current byte in
  logic [7:0]    rx_q, rx_d;             // Receive shifter
  logic [7:0]    rx_byte;                // Shifter with new bit
  logic [7:0]    cmd_q, cmd_d;           // Command being served
  logic [1:0]    abyte_q, abyte_d;       // Address byte count
  logic [17:0]   addr_q, addr_d;         // Array address counter
  logic [3:0]    id_idx_q, id_idx_d;     // Next identify byte
  logic          wr_stop_q, wr_stop_d;   // Burst write halted
  logic          sleep_arm_q, sleep_arm_d;
  logic          mode_q, mode_d;         // 0: mode 0, 1: mode 3
  logic [7:0]    tx_q, tx_d;             // Transmit shifter
  logic [2:0]    tx_cnt_q, tx_cnt_d;     // Bits left in tx_q
  logic          so_q, so_d;
  logic          so_oe_q, so_oe_d;
  logic [WW-1:0] wake_cnt_q, wake_cnt_d; // Recovery counter
  logic [7:0]    array_q [2**spi_nv_pkg::ADDR_W]; // Memory cells
  logic          wr_en, prot_hit;
  logic          push, pop, flush;
  logic [7:0]    push_data, fifo_data;
  logic          fifo_ready, fifo_valid;
  logic          cs_s, cs_rise, cs_fall, sck_rise, sck_fall;
  // Edges come from the second stage only, never the first
  assign cs_s     = sync2_q.cs_n;
  assign cs_rise  = sync2_q.cs_n && !prev_q.cs_n;
  assign cs_fall  = !sync2_q.cs_n && prev_q.cs_n;
  assign sck_rise = sync2_q.sck && !prev_q.sck;
  assign sck_fall = !sync2_q.sck && prev_q.sck;
  assign rx_byte  = {rx_q[6:0], sync2_q.si};
  assign so       = so_q;
  assign so_oe    = so_oe_q;
  // Buffer empties whenever no data stream is running
  assign flush = !((state_q == spi_nv_pkg::ST_READ) ||
                   (state_q == spi_nv_pkg::ST_ID));
  // Two entries keep the next byte ready ahead of the shifter
  byte_fifo #(.WIDTH(8), .DEPTH(2)) u_buf (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .flush     (flush),
    .in_valid  (push),
    .in_data   (push_data),
    .in_ready  (fifo_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (pop)
  );
  // Protected window test for the current write address
  always_comb begin
    case (protect_level)
      spi_nv_pkg::PROT_NONE: prot_hit = 1'b0;
      spi_nv_pkg::PROT_QTR:  prot_hit = addr_q >= spi_nv_pkg::PROT_QTR_BASE;
      spi_nv_pkg::PROT_HALF: prot_hit = addr_q >= spi_nv_pkg::PROT_HALF_BASE;
      default:               prot_hit = 1'b1;
    endcase
  end
  // Next-state logic for power, transfer and shifters
  always_comb begin
    state_d     = state_q;
    pwr_d       = pwr_q;
    bit_cnt_d   = bit_cnt_q;
    rx_d        = rx_q;
    cmd_d       = cmd_q;
    abyte_d     = abyte_q;
    addr_d      = addr_q;
    id_idx_d    = id_idx_q;
    wr_stop_d   = wr_stop_q;
    sleep_arm_d = sleep_arm_q;
    mode_d      = mode_q;
    tx_d        = tx_q;
    tx_cnt_d    = tx_cnt_q;
    so_d        = so_q;
    so_oe_d     = so_oe_q;
    wake_cnt_d  = wake_cnt_q;
    wr_en       = 1'b0;
    push        = 1'b0;
    push_data   = 8'h00;
    pop         = 1'b0;
    if (pwr_q != spi_nv_pkg::PWR_ON) begin
      // Clock and input ignored; a frame open at wake is sunk
      state_d   = cs_s ? spi_nv_pkg::ST_IDLE : spi_nv_pkg::ST_SINK;
      bit_cnt_d = 3'h0;
      so_oe_d   = 1'b0;
      if (pwr_q == spi_nv_pkg::PWR_SLEEP && cs_fall) begin
        pwr_d      = spi_nv_pkg::PWR_WAKE;
        wake_cnt_d = '0;
      end else if (pwr_q == spi_nv_pkg::PWR_WAKE) begin
        if (wake_cnt_q == WW'(WAKE_CYCLES - 1)) begin
          pwr_d = spi_nv_pkg::PWR_ON;
        end else begin
          wake_cnt_d = wake_cnt_q + 1'b1;
        end
      end
    end else if (cs_s) begin
      // Deselected: any half byte is simply dropped
      state_d     = spi_nv_pkg::ST_IDLE;
      bit_cnt_d   = 3'h0;
      tx_cnt_d    = 3'h0;
      so_oe_d     = 1'b0;
      wr_stop_d   = 1'b0;
      sleep_arm_d = 1'b0;
      id_idx_d    = 4'h0;
      if (cs_rise && sleep_arm_q && bit_cnt_q == 3'h0) begin
        pwr_d = spi_nv_pkg::PWR_SLEEP;
      end
    end else begin
      if (cs_fall) begin
        mode_d = sync2_q.sck;
      end
      // Prefetch into the buffer; stalls while it is full
      if (state_q == spi_nv_pkg::ST_READ && fifo_ready) begin
        push      = 1'b1;
        push_data = array_q[addr_q];
        addr_d    = addr_q + 1'b1;
      end else if (state_q == spi_nv_pkg::ST_ID && fifo_ready) begin
        push      = 1'b1;
        push_data = spi_nv_pkg::id_byte(id_idx_q);
        if (id_idx_q != spi_nv_pkg::ID_END_IDX) begin
          id_idx_d = id_idx_q + 1'b1;
        end
      end
      // Output changes only after falling edges, MSB first
      if (sck_fall && !flush) begin
        so_oe_d = 1'b1;
        if (tx_cnt_q == 3'h0) begin
          pop      = fifo_valid;
          so_d     = fifo_data[7];
          tx_d     = {fifo_data[6:0], 1'b0};
          tx_cnt_d = spi_nv_pkg::BYTE_LAST_BIT;
        end else begin
          so_d     = tx_q[7];
          tx_d     = {tx_q[6:0], 1'b0};
          tx_cnt_d = tx_cnt_q - 1'b1;
        end
      end
      // Input sampled on rising edges; read, identify and sink phases ignore it
      if (sck_rise && flush && state_q != spi_nv_pkg::ST_SINK) begin
        rx_d      = rx_byte;
        bit_cnt_d = bit_cnt_q + 1'b1;
        if (bit_cnt_q == spi_nv_pkg::BYTE_LAST_BIT) begin
          case (state_q)
            spi_nv_pkg::ST_IDLE: begin
              cmd_d   = rx_byte;
              abyte_d = 2'h0;
              state_d = spi_nv_pkg::ST_SINK;
              if (rx_byte == spi_nv_pkg::CMD_READ ||
                  rx_byte == spi_nv_pkg::CMD_FAST_READ ||
                  rx_byte == spi_nv_pkg::CMD_WRITE) begin
                state_d = spi_nv_pkg::ST_ADDR;
              end else if (rx_byte == spi_nv_pkg::CMD_IDENTIFY) begin
                state_d = spi_nv_pkg::ST_ID;
              end else if (rx_byte == spi_nv_pkg::CMD_SLEEP) begin
                sleep_arm_d = 1'b1;
              end
            end
            spi_nv_pkg::ST_ADDR: begin
              // Upper six address bits fall off the counter
              addr_d  = {addr_q[9:0], rx_byte};
              abyte_d = abyte_q + 1'b1;
              if (abyte_q == spi_nv_pkg::ADDR_LAST_BYTE) begin
                if (cmd_q == spi_nv_pkg::CMD_FAST_READ) begin
                  state_d = spi_nv_pkg::ST_DUMMY;
                end else if (cmd_q == spi_nv_pkg::CMD_WRITE) begin
                  state_d = spi_nv_pkg::ST_WRITE;
                end else begin
                  state_d = spi_nv_pkg::ST_READ;
                end
              end
            end
            spi_nv_pkg::ST_DUMMY: begin
              state_d = spi_nv_pkg::ST_READ;
            end
            spi_nv_pkg::ST_WRITE: begin
              // Once a protected byte is hit, the burst is frozen
              if (!wr_stop_q && prot_hit) begin
                wr_stop_d = 1'b1;
              end else if (!wr_stop_q) begin
                wr_en  = 1'b1;
                addr_d = addr_q + 1'b1;
              end
            end
            default: state_d = state_q;
          endcase
        end
      end
    end
  end
  // Synchroniser, state registers and array writes
  always_ff @(posedge core_clk) begin
    sync1_q <= {cs_n, sck, si};
    sync2_q <= sync1_q;
    if (!rst_n) begin
      prev_q      <= '1;
      state_q     <= spi_nv_pkg::ST_IDLE;
      pwr_q       <= spi_nv_pkg::PWR_ON;
      bit_cnt_q   <= 3'h0;
      rx_q        <= 8'h00;
      cmd_q       <= 8'h00;
      abyte_q     <= 2'h0;
      addr_q      <= 18'h00000;
      id_idx_q    <= 4'h0;
      wr_stop_q   <= 1'b0;
      sleep_arm_q <= 1'b0;
      mode_q      <= 1'b0;
      tx_q        <= 8'h00;
      tx_cnt_q    <= 3'h0;
      so_q        <= 1'b0;
      so_oe_q     <= 1'b0;
      wake_cnt_q  <= '0;
    end else begin
      prev_q      <= sync2_q;
      state_q     <= state_d;
      pwr_q       <= pwr_d;
      bit_cnt_q   <= bit_cnt_d;
      rx_q        <= rx_d;
      cmd_q       <= cmd_d;
      abyte_q     <= abyte_d;
      addr_q      <= addr_d;
      id_idx_q    <= id_idx_d;
      wr_stop_q   <= wr_stop_d;
      sleep_arm_q <= sleep_arm_d;
      mode_q      <= mode_d;
      tx_q        <= tx_d;
      tx_cnt_q    <= tx_cnt_d;
      so_q        <= so_d;
      so_oe_q     <= so_oe_d;
      wake_cnt_q  <= wake_cnt_d;
    end
    if (wr_en) begin
      array_q[addr_q] <= rx_byte;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  deselect_float_a: assert property (
    cs_rise |=> !so_oe_q) else $error("output driven after deselect");
  sleep_hiz_a: assert property (
    pwr_q != spi_nv_pkg::PWR_ON |-> !so_oe_q)
    else $error("output driven while asleep");
  commit_bit8_a: assert property (
    wr_en |-> sck_rise && bit_cnt_q == 3'h7 && !cs_s &&
              state_q == spi_nv_pkg::ST_WRITE)
    else $error("array write outside a full byte");
  write_stop_a: assert property (
    state_q == spi_nv_pkg::ST_WRITE && wr_stop_q
    |-> !wr_en ##1 addr_q == $past(addr_q))
    else $error("frozen burst still writes");
  sleep_entry_a: assert property (
    pwr_q == spi_nv_pkg::PWR_ON && cs_rise && sleep_arm_q &&
    bit_cnt_q == 3'h0 |=> pwr_q == spi_nv_pkg::PWR_SLEEP)
    else $error("sleep not entered");
  wake_start_a: assert property (
    pwr_q == spi_nv_pkg::PWR_SLEEP && cs_fall
    |=> pwr_q == spi_nv_pkg::PWR_WAKE) else $error("wake not started");
  wake_bound_a: assert property (
    pwr_q == spi_nv_pkg::PWR_WAKE |-> wake_cnt_q < WW'(WAKE_CYCLES))
    else $error("recovery too long");
  mode_pick_a: assert property (
    pwr_q == spi_nv_pkg::PWR_ON && cs_fall
    |=> mode_q == $past(sync2_q.sck)) else $error("mode not captured");
  read_wrap_a: assert property (
    state_q == spi_nv_pkg::ST_READ && push &&
    addr_q == spi_nv_pkg::ADDR_MAX |=> addr_q == 18'h00000)
    else $error("address did not wrap");
endmodule

// ===== rtl/spi_nv_pkg.sv
package spi_nv_pkg;
  // Array geometry and the wrap point of the address counter
  localparam int          ADDR_W   = 18;
  localparam logic [17:0] ADDR_MAX = 18'h3ffff;
  // Lowest protected address for the quarter and half protect levels
  localparam logic [17:0] PROT_QTR_BASE  = 18'h30000;
  localparam logic [17:0] PROT_HALF_BASE = 18'h20000;
  localparam logic [1:0]  PROT_NONE = 2'h0;
  localparam logic [1:0]  PROT_QTR  = 2'h1;
  localparam logic [1:0]  PROT_HALF = 2'h2;
  // Command bytes
  localparam logic [7:0] CMD_READ          = 8'h03;
  localparam logic [7:0] CMD_FAST_READ     = 8'h0b;
  localparam logic [7:0] CMD_WRITE         = 8'h02;
  localparam logic [7:0] CMD_SLEEP         = 8'hb9;
  localparam logic [7:0] CMD_IDENTIFY      = 8'h9f;
  // Bit and byte counters
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
  // Identification layout: six continuation bytes, bank byte, product
  localparam logic [3:0] ID_BANK_IDX = 4'h6;
  localparam logic [3:0] ID_HI_IDX   = 4'h7;
  localparam logic [3:0] ID_LO_IDX   = 4'h8;
  localparam logic [3:0] ID_END_IDX  = 4'h9;
  localparam logic [7:0] ID_CONT     = 8'h5a; // Arbitrary value
  localparam logic [7:0] ID_BANK     = 8'h3c; // Arbitrary value
  localparam logic [2:0] ID_FAMILY   = 3'h2;  // Arbitrary value
  localparam logic [4:0] ID_DENSITY  = 5'h0a; // Arbitrary value
  localparam logic [1:0] ID_SUB      = 2'h1;  // Arbitrary value
  localparam logic [2:0] ID_REV      = 3'h3;  // Arbitrary value
  localparam logic [2:0] ID_RSVD     = 3'h0;
  // Product word: family, density, sub code, revision, reserved
  localparam logic [15:0] PROD_ID =
    {ID_FAMILY, ID_DENSITY, ID_SUB, ID_REV, ID_RSVD};
  // Wake recovery time and its count at the core clock rate
  localparam int CLK_MHZ            = 40;
  localparam int WAKE_RECOVERY_TIME = 450; // Microseconds
  localparam int REC_CYCLES         = WAKE_RECOVERY_TIME * CLK_MHZ;
  localparam int WAKE_CNT_W         = 16;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_DUMMY, ST_READ, ST_WRITE, ST_ID, ST_SINK
  } xfer_e;

  typedef enum logic [1:0] {PWR_ON, PWR_SLEEP, PWR_WAKE} pwr_e;

  // The three serial inputs travel together through the synchroniser
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } spi_pins_s;

  // Identification byte at a given position of the readout
  function automatic logic [7:0] id_byte(input logic [3:0] idx);
    logic [7:0] b;
    b = 8'h00;
    if (idx < ID_BANK_IDX) begin
      b = ID_CONT;
    end else if (idx == ID_BANK_IDX) begin
      b = ID_BANK;
    end else if (idx == ID_HI_IDX) begin
      b = PROD_ID[15:8];
    end else if (idx == ID_LO_IDX) begin
      b = PROD_ID[7:0];
    end
    return b;
  endfunction
endpackage

// ===== rtl/byte_fifo.sv
`timescale 1ns/1ps
// Small FIFO with flush; out side may stall so the in side really fills
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];   // Storage
  logic [PW-1:0]    wr_ptr_q, wr_ptr_d;
  logic [PW-1:0]    rd_ptr_q, rd_ptr_d;
  logic [PW:0]      cnt_q, cnt_d;    // Entries held
  logic             push, pop;

  assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count update; flush drops everything held
  always_comb begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    cnt_d    = cnt_q;
    if (flush) begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
      cnt_d    = '0;
    end else begin
      if (push) begin
        wr_ptr_d = (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_d = (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  // Registers only; storage needs no reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q    <= cnt_d;
    end
    if (push && !flush) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end
endmodule

// ===== bench/spi_host_model.sv
`timescale 1ns/1ps
// Host side of the serial link: drives select, clock and data in
module spi_host_model (
  input  wire logic core_clk,
  input  wire logic so,
  input  wire logic so_oe,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  logic mode3_q; // Idle clock level of the open frame

  // Deselected, clock parked low, data line at a known level
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    mode3_q = 1'b0;
  end

  // Park the clock first, then select; the level picks the mode
  task automatic open_frame(input logic mode3);
    @(posedge core_clk);
    #2;
    mode3_q = mode3;
    sck = mode3;
    #100;
    cs_n = 1'b0;
    #100;
  endtask

  // Shift nb bits MSB first; each read bit is taken just before the
  // fall that ends its cycle, so the output has a full period to settle
  task automatic shift(input logic [7:0] tx, input int nb,
                       output logic [7:0] rx, output logic oe);
    rx = 8'h00;
    oe = 1'b0;
    for (int i = 7; i > 7 - nb; i--) begin
      sck = 1'b0;
      si = tx[i];
      #100;
      sck = 1'b1;
      #100;
      rx[i] = so_oe ? so : ~so; // A floating line reads wrong
      oe = oe | so_oe;
    end
  endtask

  // Deselect; the released data line flips so a stale level is no help
  task automatic close_frame();
    if (!mode3_q) begin
      sck = 1'b0;
    end
    #100;
    cs_n = 1'b1;
    si = ~si;
    #200;
  endtask
endmodule

// ===== bench/spi_nv_memory_read_sleep_id_test.sv
`timescale 1ns/1ps
// Self-checking bench: reference array against the design's read data
module spi_nv_memory_read_sleep_id_test;
  localparam int WAKE = 20; // Short recovery count for simulation
  logic       core_clk;
  logic       rst_n;
  logic       cs_n;
  logic       sck;
  logic       si;
  logic       so;
  logic       so_oe;
  logic [1:0] protect_level;
  logic [7:0] rx;
  logic       oe;
  int         bad_count;
  int         checks_done;
  int         cycles;
  logic [7:0] mem [int]; // Reference contents of written bytes

  spi_nv_memory #(.WAKE_CYCLES(WAKE)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck),
    .si(si), .protect_level(protect_level), .so(so), .so_oe(so_oe));

  spi_host_model h (
    .core_clk(core_clk), .so(so), .so_oe(so_oe), .cs_n(cs_n),
    .sck(sck), .si(si));

  // Core clock, 25 ns period
  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  // Counts and verdict, then the end of the run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard, well above the ten thousand or so cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Protected range for each protect level
  function automatic bit prot(input logic [17:0] a, input int lvl);
    return lvl == 3 || (lvl == 2 && a >= 18'h20000) ||
           (lvl == 1 && a >= 18'h30000);
  endfunction

  // Command plus three address bytes; the top six bits are noise
  task automatic send_head(input logic [7:0] cmd, input logic [17:0] a);
    logic [5:0] top;
    top = 6'($urandom);
    h.open_frame(1'($urandom));
    h.shift(cmd, 8, rx, oe);
    h.shift({top, a[17:16]}, 8, rx, oe);
    h.shift(a[15:8], 8, rx, oe);
    h.shift(a[7:0], 8, rx, oe);
  endtask

  // Burst write; the model freezes at the first protected address
  task automatic do_write(input logic [17:0] addr, input int n,
                          input int lvl);
    logic [17:0] a;
    logic [7:0]  d;
    bit          stop;
    a = addr;
    stop = 0;
    protect_level = 2'(lvl);
    send_head(spi_nv_pkg::CMD_WRITE, addr);
    repeat (n) begin
      d = 8'($urandom);
      h.shift(d, 8, rx, oe);
      if (prot(a, lvl)) begin
        stop = 1;
      end
      if (!stop) begin
        mem[a] = d;
        a = a + 18'h1;
      end
    end
    h.close_frame();
  endtask

  // Normal or fast read with random data in, compared byte by byte
  task automatic do_read(input logic [17:0] addr, input int n,
                         input bit fast);
    logic [17:0] a;
    a = addr;
    send_head(fast ? spi_nv_pkg::CMD_FAST_READ : spi_nv_pkg::CMD_READ,
              addr);
    if (fast) begin
      h.shift(8'($urandom), 8, rx, oe);
    end
    repeat (n) begin
      h.shift(8'($urandom), 8, rx, oe);
      check(32'(oe), 32'h1);
      check(32'(rx), 32'(mem[a]));
      a = a + 18'h1;
    end
    h.close_frame();
    check(32'(so_oe), 32'h0);
  endtask

  // Expected identification byte at a position of the readout
  function automatic logic [7:0] id_exp(input int i);
    logic [15:0] p;
    p = {spi_nv_pkg::ID_FAMILY, spi_nv_pkg::ID_DENSITY,
         spi_nv_pkg::ID_SUB, spi_nv_pkg::ID_REV, spi_nv_pkg::ID_RSVD};
    if (i < 6) begin
      return spi_nv_pkg::ID_CONT;
    end else if (i == 6) begin
      return spi_nv_pkg::ID_BANK;
    end else if (i == 7) begin
      return p[15:8];
    end else if (i == 8) begin
      return p[7:0];
    end
    return 8'h00;
  endfunction

  initial begin
    logic [7:0] d;
    void'($urandom(62078));
    rst_n = 1'b0;
    protect_level = 2'h0;
    repeat (5) @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    repeat (3) @(posedge core_clk);
    #2;
    // Burst write across the top address, read back both ways
    do_write(18'h3fffe, 4, 0);
    do_read(18'h3fffe, 4, 0);
    do_read(18'h3fffe, 4, 1);
    $display("test wrap done");
    // Each protect level stops the burst at its own boundary
    do_write(18'h1fffe, 4, 0);
    do_write(18'h2fffe, 4, 0);
    for (int lvl = 1; lvl < 4; lvl++) begin
      do_write(lvl == 1 ? 18'h2fffe : 18'h1fffe, 4, lvl);
      do_read(lvl == 1 ? 18'h2fffe : 18'h1fffe, 4, lvl[0]);
    end
    $display("test protect done");
    // Cut second byte: first stored, second untouched
    do_write(18'h00100, 2, 0);
    send_head(spi_nv_pkg::CMD_WRITE, 18'h00100);
    d = 8'($urandom);
    h.shift(d, 8, rx, oe);
    mem[18'h00100] = d;
    h.shift(8'($urandom), 5, rx, oe);
    h.close_frame();
    do_read(18'h00100, 2, 0);
    // Sleep command cut mid-byte must not put the device to sleep
    h.open_frame(1'b0);
    h.shift(spi_nv_pkg::CMD_SLEEP, 5, rx, oe);
    h.close_frame();
    do_read(18'h00100, 1, 1);
    // Unknown command: rest of the frame is sunk, output stays off
    h.open_frame(1'($urandom));
    h.shift(8'h00, 8, rx, oe);
    h.shift(8'($urandom), 8, rx, oe);
    check(32'(oe), 32'h0);
    h.close_frame();
    $display("test cut done");
    // Identification readout, running past its end
    h.open_frame(1'($urandom));
    h.shift(spi_nv_pkg::CMD_IDENTIFY, 8, rx, oe);
    for (int i = 0; i < 10; i++) begin
      h.shift(8'($urandom), 8, rx, oe);
      check(32'(rx), 32'(id_exp(i)));
    end
    h.close_frame();
    $display("test identify done");
    // Sleep, then a throwaway read that must see no output
    h.open_frame(1'b0);
    h.shift(spi_nv_pkg::CMD_SLEEP, 8, rx, oe);
    h.close_frame();
    send_head(spi_nv_pkg::CMD_READ, 18'h00100);
    h.shift(8'($urandom), 8, rx, oe);
    check(32'(oe), 32'h0);
    h.shift(8'($urandom), 8, rx, oe);
    check(32'(oe), 32'h0);
    h.close_frame();
    repeat (WAKE) @(posedge core_clk);
    #2;
    do_read(18'h00100, 2, 1);
    $display("test sleep done");
    give_verdict();
  end
endmodule
